/* File: hdl/bfbi_pkg.sv */
// Constants, types and helpers for the banked flash bus host controller
package bfbi_pkg;

  // ----------------------------------------
  // Widths, bit positions, timing
  // ----------------------------------------
  localparam int          ADDR_W     = 23;
  localparam int          DATA_W     = 32;
  localparam int          PAGE_LSB   = 3;
  localparam int          BANK_LSB   = 20;
  localparam int          BOOT_LSB   = 13;
  localparam int          POLL_BIT   = 7;
  localparam int          TOGGLE_BIT = 6;
  localparam int          CLK_NS     = 50;
  localparam int          T_ACC_NS   = 120;
  localparam int          T_PACC_NS  = 30;
  localparam int          T_WP_NS    = 50;
  localparam int          T_RST_NS   = 500;
  localparam logic [7:0]  SYNC_LAT   = 8'h02;

  function automatic logic [7:0] nsToCyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return c[7:0];
  endfunction : nsToCyc

  localparam logic [7:0]  CYC_ACC    = nsToCyc(T_ACC_NS);
  localparam logic [7:0]  CYC_PACC   = nsToCyc(T_PACC_NS);
  localparam logic [7:0]  CYC_WP     = nsToCyc(T_WP_NS);
  localparam logic [7:0]  CYC_RST    = nsToCyc(T_RST_NS);

  // ----------------------------------------
  // Command sequence words
  // ----------------------------------------
  localparam logic [22:0] UNLK_A1    = 23'h000555;
  localparam logic [22:0] UNLK_A2    = 23'h0002AA;
  localparam logic [15:0] CMD_UNLK1  = 16'h00AA;
  localparam logic [15:0] CMD_UNLK2  = 16'h0055;
  localparam logic [15:0] CMD_PROG   = 16'h00A0;
  localparam logic [15:0] CMD_ERASE  = 16'h0080;
  localparam logic [15:0] CMD_SECT   = 16'h0030;
  localparam logic [15:0] CMD_SUSP   = 16'h00B0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_READ   = 3'b000,
    OP_WRITE  = 3'b001,
    OP_PROG   = 3'b010,
    OP_ERASE  = 3'b011,
    OP_SUSP   = 3'b100,
    OP_RESUME = 3'b101,
    OP_RESET  = 3'b110
  } bfbi_op_t;

  typedef struct packed {
    bfbi_op_t          op;
    logic              bypass;
    logic [1:0]        half;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bfbi_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              last;
  } bfbi_step_t;

  typedef struct packed {
    logic [1:0]        csN;
    logic [1:0]        weN;
    logic              oeN;
    logic              rstN;
    logic              bootProtect;
    logic [ADDR_W-1:0] addr;
  } bfbi_pins_t;

endpackage : bfbi_pkg

/* File: hdl/bfbi_host.sv */
// Host-side controller driving a four-bank page-mode flash over its pins
//
// Summary of operation
// - Read is CS and OE low, write is CS and WE low, never both enables.
// - Chip selects high when idle with no operation busy, so the device sits in standby.
// - Word program uses four writes, or two in unlock bypass mode.
// - Completion is found by polling the toggle status bit on reads.
// - Entry and exit sequences for the one-time region use raw writes.
// - Boot protect pin is driven high only to modify boot sectors.
// - Password protection commands are issued as raw write sequences.
// - Address bits 22..3 pick the page, bits 2..0 the word.
`timescale 1ns/1ns
module bfbi_host
  import bfbi_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              reqValid,
  input  wire bfbi_req_t         req,
  output logic                   reqAck,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData,
  output logic                   opDone,
  output logic                   opBusy,
  output logic                   eraseSuspended,
  output bfbi_pins_t             pins,
  output logic [DATA_W-1:0]      dataBusOut,
  output logic                   dataBusOe,
  input  wire logic [DATA_W-1:0] dataBusIn,
  input  wire logic              readyBusyIn
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] bankOf(input logic [ADDR_W-1:0] a);
    if (a[22:20] == 3'h0) return 2'h0;
    if (a[22:20] == 3'h7) return 2'h3;
    return a[22] ? 2'h2 : 2'h1;
  endfunction : bankOf

  function automatic logic isBoot(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:BOOT_LSB] == '0) || (a[ADDR_W-1:BOOT_LSB] == '1);
  endfunction : isBoot

  function automatic logic isPE(input bfbi_op_t o);
    return (o == OP_PROG) || (o == OP_ERASE);
  endfunction : isPE

  function automatic bfbi_step_t seqStep(input bfbi_req_t r,
                                         input logic [2:0] i);
    bfbi_step_t s;
    logic [2:0] k;
    s = '{addr: UNLK_A1, data: {2{CMD_UNLK1}}, last: 1'b0};
    k = r.bypass ? 3'(i + 3'h2) : i;
    case (r.op)
      OP_PROG: begin
        case (k)
          3'h1:    s = '{UNLK_A2, {2{CMD_UNLK2}}, 1'b0};
          3'h2:    s = '{UNLK_A1, {2{CMD_PROG}}, 1'b0};
          3'h3:    s = '{r.addr, r.data, 1'b1};
          default: s = s;
        endcase
      end
      OP_ERASE: begin
        case (i)
          3'h1, 3'h4: s = '{UNLK_A2, {2{CMD_UNLK2}}, 1'b0};
          3'h2:       s = '{UNLK_A1, {2{CMD_ERASE}}, 1'b0};
          3'h5:       s = '{r.addr, {2{CMD_SECT}}, 1'b1};
          default:    s = s;
        endcase
      end
      OP_SUSP:   s = '{r.addr, {2{CMD_SUSP}}, 1'b1};
      OP_RESUME: s = '{r.addr, {2{CMD_RESUME}}, 1'b1};
      default:   s = '{r.addr, r.data, 1'b1};
    endcase
    return s;
  endfunction : seqStep

  // ----------------------------------------
  // State and input synchronisers
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE  = 3'b001,
    ST_RD    = 3'b010,
    ST_PAGE  = 3'b011,
    ST_WSET  = 3'b100,
    ST_WPUL  = 3'b101,
    ST_WHLD  = 3'b110,
    ST_POLL  = 3'b111
  } bfbi_state_t;

  bfbi_state_t       state_reg;
  bfbi_req_t         cur_reg;
  logic [7:0]        wait_reg;
  logic [2:0]        step_reg;
  logic [ADDR_W-1:0] busyAddr_reg;
  logic              prevTog_reg;
  logic              prevValid_reg;
  logic [DATA_W-1:0] dMeta_reg;
  logic [DATA_W-1:0] dSync_reg;
  logic              rbMeta_reg;
  logic              rbSync_reg;
  bfbi_step_t        stepNow;
  logic              take;
  logic              pollStable;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dMeta_reg  <= '0;
      dSync_reg  <= '0;
      rbMeta_reg <= 1'b0;
      rbSync_reg <= 1'b0;
    end else begin
      dMeta_reg  <= dataBusIn;
      dSync_reg  <= dMeta_reg;
      rbMeta_reg <= readyBusyIn;
      rbSync_reg <= rbMeta_reg;
    end
  end

  assign stepNow    = seqStep(cur_reg, step_reg);
  assign pollStable = prevValid_reg && rbSync_reg
                      && (prevTog_reg == dSync_reg[TOGGLE_BIT]);

  // Request acceptance
  always_comb begin
    take = 1'b0;
    if (reqValid && state_reg == ST_IDLE) begin
      if (!opBusy)
        take = (req.op != OP_RESUME) || eraseSuspended;
      else
        take = (req.op == OP_READ
                && bankOf(req.addr) != bankOf(busyAddr_reg))
               || (req.op == OP_SUSP && cur_reg.op == OP_ERASE)
               || (req.op == OP_RESET);
    end else if (reqValid && state_reg == ST_PAGE) begin
      take = req.op == OP_READ && req.half == cur_reg.half
             && req.addr[ADDR_W-1:PAGE_LSB]
                == cur_reg.addr[ADDR_W-1:PAGE_LSB];
    end
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_RESET;
      cur_reg   <= '0;
      wait_reg  <= CYC_RST;
      step_reg  <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_RESET: begin
          if (wait_reg <= 8'h01) state_reg <= ST_IDLE;
          else wait_reg <= wait_reg - 8'h01;
        end
        ST_IDLE, ST_PAGE: begin
          step_reg <= 3'h0;
          if (take) begin
            cur_reg <= req;
            unique case (req.op)
              OP_READ: begin
                state_reg <= ST_RD;
                wait_reg  <= (state_reg == ST_PAGE ? CYC_PACC : CYC_ACC)
                             + SYNC_LAT;
              end
              OP_RESET: begin
                state_reg <= ST_RESET;
                wait_reg  <= CYC_RST;
              end
              default: state_reg <= ST_WSET;
            endcase
          end else if (state_reg == ST_PAGE) begin
            state_reg <= ST_IDLE;
          end else if (opBusy) begin
            state_reg <= ST_POLL;
            wait_reg  <= CYC_ACC + SYNC_LAT;
          end
        end
        ST_RD: begin
          if (wait_reg <= 8'h01) state_reg <= ST_PAGE;
          else wait_reg <= wait_reg - 8'h01;
        end
        ST_POLL: begin
          if (wait_reg <= 8'h01) state_reg <= ST_IDLE;
          else wait_reg <= wait_reg - 8'h01;
        end
        ST_WSET: begin
          state_reg <= ST_WPUL;
          wait_reg  <= CYC_WP;
        end
        ST_WPUL: begin
          if (wait_reg <= 8'h01) state_reg <= ST_WHLD;
          else wait_reg <= wait_reg - 8'h01;
        end
        ST_WHLD: begin
          step_reg  <= step_reg + 3'h1;
          state_reg <= stepNow.last ? ST_IDLE : ST_WSET;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins       <= '{csN: 2'b11, weN: 2'b11, oeN: 1'b1, rstN: 1'b0,
                      bootProtect: 1'b0, addr: '0};
      dataBusOut <= '0;
      dataBusOe  <= 1'b0;
    end else begin
      pins.rstN <= !(state_reg == ST_RESET && wait_reg > 8'h01);
      pins.oeN  <= 1'b1;
      pins.weN  <= 2'b11;
      dataBusOe <= 1'b0;
      // Cleared before take so a boot write taken now keeps it
      if (opDone) pins.bootProtect <= 1'b0;
      if (take) begin
        pins.csN  <= ~req.half;
        pins.addr <= (req.op == OP_READ) ? req.addr : pins.addr;
        if (isPE(req.op))
          pins.bootProtect <= isBoot(req.addr);
      end else if (state_reg == ST_IDLE && opBusy) begin
        pins.csN  <= 2'b11;
        pins.addr <= busyAddr_reg;
      end else if (state_reg == ST_IDLE || state_reg == ST_PAGE) begin
        pins.csN <= 2'b11;
      end
      if (state_reg == ST_IDLE && opBusy && !take)
        pins.csN <= 2'b00;
      // Output enable rises between polls so the toggle bit can move
      if (state_reg == ST_RD || state_reg == ST_POLL
          || (take && req.op == OP_READ))
        pins.oeN <= 1'b0;
      if (state_reg == ST_WSET) begin
        pins.addr  <= stepNow.addr;
        dataBusOut <= stepNow.data;
        dataBusOe  <= 1'b1;
        pins.weN   <= ~cur_reg.half;
        pins.oeN   <= 1'b1;
      end else if (state_reg == ST_WPUL) begin
        dataBusOe <= 1'b1;
        pins.weN  <= (wait_reg <= 8'h01) ? 2'b11 : ~cur_reg.half;
      end else if (state_reg == ST_WHLD) begin
        dataBusOe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Completion tracking and answers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opBusy         <= 1'b0;
      eraseSuspended <= 1'b0;
      busyAddr_reg   <= '0;
      prevTog_reg    <= 1'b0;
      prevValid_reg  <= 1'b0;
      opDone         <= 1'b0;
      reqAck         <= 1'b0;
      rspValid       <= 1'b0;
      rspData        <= '0;
    end else begin
      reqAck   <= take;
      opDone   <= 1'b0;
      rspValid <= state_reg == ST_RD && wait_reg <= 8'h01;
      if (state_reg == ST_RD && wait_reg <= 8'h01) rspData <= dSync_reg;
      if (state_reg == ST_WHLD && stepNow.last
          && cur_reg.op != OP_WRITE) begin
        opBusy        <= 1'b1;
        busyAddr_reg  <= cur_reg.addr;
        prevValid_reg <= 1'b0;
        if (cur_reg.op == OP_RESUME) eraseSuspended <= 1'b0;
      end else if (state_reg == ST_POLL && wait_reg <= 8'h01) begin
        prevTog_reg   <= dSync_reg[TOGGLE_BIT];
        prevValid_reg <= 1'b1;
        if (pollStable) begin
          opBusy  <= 1'b0;
          opDone  <= 1'b1;
          if (cur_reg.op == OP_SUSP) eraseSuspended <= 1'b1;
        end
      end
      if (state_reg == ST_RESET) begin
        opBusy         <= 1'b0;
        eraseSuspended <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_enables_exclusive;
    @(posedge core_clk) disable iff (sys_rst)
      !pins.oeN |-> pins.weN == 2'b11;
  endproperty
  a_enables_exclusive: assert property (p_enables_exclusive)
    else $error("output and write enable low together");

  property p_reset_floats;
    @(posedge core_clk) disable iff (sys_rst)
      !pins.rstN |-> !dataBusOe && pins.weN == 2'b11;
  endproperty
  a_reset_floats: assert property (p_reset_floats)
    else $error("bus driven during device reset");

  property p_reset_width;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(pins.rstN) |-> !$past(pins.rstN, 2);
  endproperty
  a_reset_width: assert property (p_reset_width)
    else $error("device reset pulse too short");

  property p_idle_deselect;
    @(posedge core_clk) disable iff (sys_rst)
      (state_reg == ST_IDLE && !opBusy && !reqValid)
        |=> pins.csN == 2'b11;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("chip select held while idle");

  property p_write_data;
    @(posedge core_clk) disable iff (sys_rst)
      (pins.weN != 2'b11)
        |-> dataBusOe ##1 (dataBusOe && $stable(pins.addr));
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write pulse without stable address and data");

  property p_no_pe_busy;
    @(posedge core_clk) disable iff (sys_rst)
      (state_reg == ST_IDLE && opBusy && reqValid && isPE(req.op))
        |=> !reqAck;
  endproperty
  a_no_pe_busy: assert property (p_no_pe_busy)
    else $error("program or erase taken while busy");

  property p_other_bank;
    @(posedge core_clk) disable iff (sys_rst)
      (reqAck && cur_reg.op == OP_READ && opBusy)
        |-> bankOf(cur_reg.addr) != bankOf(busyAddr_reg);
  endproperty
  a_other_bank: assert property (p_other_bank)
    else $error("read taken in the busy bank");

  property p_boot_pin;
    @(posedge core_clk) disable iff (sys_rst)
      (state_reg == ST_WPUL && isPE(cur_reg.op) && isBoot(cur_reg.addr))
        |-> pins.bootProtect;
  endproperty
  a_boot_pin: assert property (p_boot_pin)
    else $error("boot sector written with protect pin low");

  property p_done_after_poll;
    @(posedge core_clk) disable iff (sys_rst)
      opDone |-> $past(rbSync_reg) && !opBusy;
  endproperty
  a_done_after_poll: assert property (p_done_after_poll)
    else $error("completion without ready");

  c_page_read: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == ST_PAGE && take);
  c_bank_read: cover property (@(posedge core_clk) disable iff (sys_rst)
    reqAck && opBusy && cur_reg.op == OP_READ);
  c_suspend: cover property (@(posedge core_clk) disable iff (sys_rst)
    $rose(eraseSuspended));

endmodule : bfbi_host

/* File: bench/bfbi_flash_model.sv */
// Behavioural flash device answering the host controller pins
`timescale 1ns/1ns
module bfbi_flash_model
  import bfbi_pkg::*;
#(
  parameter int BUSY_CYC = 60
)(
  input  wire logic              core_clk,
  input  wire bfbi_pins_t        pins,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   readyBusy
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] opData;
  logic              tgl;
  logic              flip;
  logic              prevWe;
  logic              prevOe;
  logic              erArm;
  logic [1:0]        opBank;
  int                step;
  int                busyCnt;
  int                dq[$];
  wire logic         prot = !pins.bootProtect &&
                            (pins.addr < 23'h002000 ||
                             pins.addr >= 23'h7FE000);

  function automatic logic [1:0] bankOf(input logic [22:0] a);
    if (a[22:20] == 3'h0) return 2'h0;
    if (a[22:20] == 3'h7) return 2'h3;
    return a[22] ? 2'h2 : 2'h1;
  endfunction : bankOf

  function automatic int sectOf(input logic [22:0] a);
    if (a < 23'h008000 || a >= 23'h7F8000) return 4096 + int'(a >> 12);
    return int'(a >> 15);
  endfunction : sectOf

  // ----------------------------------------
  // Command decode and busy timer
  // ----------------------------------------
  always @(posedge core_clk or negedge pins.rstN) begin
    if (!pins.rstN) begin
      step = 0;
      busyCnt = 0;
      tgl = 1'b0;
      flip = 1'b0;
      erArm = 1'b0;
      prevWe = 1'b1;
      prevOe = 1'b1;
    end else begin
      flip = ~flip;
      if (busyCnt > 0) busyCnt = busyCnt - 1;
      if (prevOe && !pins.oeN && busyCnt > 0) tgl = ~tgl;
      if (!prevWe && pins.weN[0] && !pins.csN[0]) begin
        if (busyCnt > 0) step = 0;
        else if (step == 0) step = (dataIn[15:0] == CMD_UNLK1) ? 1 : 0;
        else if (step == 1) step = (dataIn[15:0] == CMD_UNLK2) ? 2 : 0;
        else if (step == 2) begin
          step = (dataIn[15:0] == CMD_PROG) ? 3 : 0;
          if (erArm && dataIn[15:0] == CMD_SECT && !prot) begin
            foreach (mem[k])
              if (sectOf(23'(k)) == sectOf(pins.addr)) dq.push_back(k);
            foreach (dq[i]) mem.delete(dq[i]);
            dq.delete();
          end
          if (erArm && dataIn[15:0] == CMD_SECT) busyCnt = BUSY_CYC;
          erArm = (dataIn[15:0] == CMD_ERASE);
          opData = '0;
          opBank = bankOf(pins.addr);
        end else begin
          if (!prot) mem[pins.addr] = word & dataIn;
          opData = dataIn;
          opBank = bankOf(pins.addr);
          busyCnt = prot ? 2 : BUSY_CYC;
          step = 0;
        end
      end
      prevWe = pins.weN[0];
      prevOe = pins.oeN;
    end
  end

  assign readyBusy = (busyCnt == 0);

  // ----------------------------------------
  // Read path; released lines show a moving pattern
  // ----------------------------------------
  always @* begin
    word = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : '1;
    if (busyCnt > 0 && bankOf(pins.addr) == opBank)
      word = {8'h00, ~opData[23], tgl, 6'h00, 8'h00, ~opData[7], tgl, 6'h00};
    dataOut = {16{flip, ~flip}};
    if (pins.rstN && !pins.oeN && !pins.csN[0] && pins.weN[0])
      dataOut[15:0] = word[15:0];
    if (pins.rstN && !pins.oeN && !pins.csN[1] && pins.weN[1])
      dataOut[31:16] = word[31:16];
  end
endmodule : bfbi_flash_model

/* File: bench/testbench.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
module testbench
  import bfbi_pkg::*;
;
  logic              core_clk;
  logic              sys_rst;
  logic              reqValid;
  logic              reqAck;
  logic              rspValid;
  logic              opDone;
  logic              opBusy;
  logic              eraseSuspended;
  logic              dataBusOe;
  logic              readyBusyIn;
  bfbi_req_t         req;
  bfbi_pins_t        pins;
  logic [DATA_W-1:0] rspData;
  logic [DATA_W-1:0] dataBusOut;
  logic [DATA_W-1:0] dataBusIn;
  bit                ok;
  int                fails;
  int                n_compared;

  bfbi_host DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .req(req), .reqAck(reqAck),
    .rspValid(rspValid), .rspData(rspData), .opDone(opDone),
    .opBusy(opBusy), .eraseSuspended(eraseSuspended), .pins(pins),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
    .dataBusIn(dataBusIn), .readyBusyIn(readyBusyIn));

  bfbi_flash_model #(.BUSY_CYC(60)) flashModel (.core_clk(core_clk),
    .pins(pins), .dataIn(dataBusOut), .dataOut(dataBusIn),
    .readyBusy(readyBusyIn));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic waitHi(ref logic s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge core_clk);
      #1;
      if (s === 1'b1) return;
    end
    check(32'h0, 32'h1);
  endtask : waitHi

  // Raise a request, hold it until taken or lim cycles pass, then drop it one cycle later if drop is set
  task automatic issue(input bfbi_op_t op, input logic [22:0] a,
                       input logic [31:0] d, input int lim, input bit drop);
    ok = 1'b0;
    @(posedge core_clk);
    reqValid <= 1'b1;
    req <= '{op: op, bypass: 1'b0, half: 2'b11, addr: a, data: d};
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge core_clk);
      #1 ok = (reqAck === 1'b1);
    end
    if (drop) begin
      @(posedge core_clk);
      reqValid <= 1'b0;
    end
  endtask : issue

  task automatic rd(input logic [22:0] a, input logic [31:0] exp);
    issue(OP_READ, a, '0, 40, 1'b1);
    waitHi(rspValid, 40);
    check(rspData, exp);
  endtask : rd

  task automatic op(input bfbi_op_t o, input logic [22:0] a,
                    input logic [31:0] d);
    issue(o, a, d, 40, 1'b1);
    waitHi(opDone, 600);
  endtask : op

  task automatic t_page();
    issue(OP_READ, 23'h7F0010, '0, 40, 1'b0);
    @(posedge core_clk);
    req.addr <= 23'h7F0011;
    waitHi(rspValid, 40);
    check(rspData, 32'h12345678);
    waitHi(reqAck, 40);
    @(posedge core_clk);
    reqValid <= 1'b0;
    waitHi(rspValid, int'(CYC_PACC + SYNC_LAT));
    check(rspData, 32'hCAFE0001);
  endtask : t_page

  task automatic t_simul();
    issue(OP_PROG, 23'h100200, 32'h0BADF00D, 40, 1'b1);
    waitHi(opBusy, 20);
    check(32'(opBusy), 32'h1);
    rd(23'h7F0010, 32'h12345678);
    issue(OP_PROG, 23'h7F0020, 32'h0, 20, 1'b1);
    check(32'(ok), 32'h0);
    waitHi(opDone, 600);
    rd(23'h100200, 32'h0BADF00D);
  endtask : t_simul

  initial begin
    #1000000;
    fails++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    report_and_stop();
  end

  initial begin
    reqValid = 1'b0;
    req = '0;
    sys_rst = 1'b1;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge core_clk);
    check(32'({pins.csN, pins.oeN, pins.rstN, dataBusOe}), 32'h1C);
    sys_rst <= 1'b0;
    rd(23'h7F0010, 32'hFFFFFFFF);
    op(OP_PROG, 23'h7F0010, 32'h12345678);
    rd(23'h7F0010, 32'h12345678);
    op(OP_PROG, 23'h7F0011, 32'hCAFE0001);
    t_page();
    t_simul();
    op(OP_ERASE, 23'h7F0010, '0);
    check(32'(eraseSuspended), 32'h0);
    rd(23'h7F0010, 32'hFFFFFFFF);
    rd(23'h100200, 32'h0BADF00D);
    op(OP_PROG, 23'h000100, 32'h55AA55AA);
    issue(OP_WRITE, UNLK_A1, 32'h00F000F0, 40, 1'b1);
    check(32'(ok), 32'h1);
    repeat (12) @(posedge core_clk);
    check(32'(opBusy), 32'h0);
    rd(23'h000100, 32'h55AA55AA);
    report_and_stop();
  end
endmodule : testbench
